// *** logic/projectile_speed_timer.sv ***
`timescale 1ns/1ns
// Behaviour
// - rising first gate line starts the interval counter.
// - rising second gate line stops the interval counter.
// - interval runs between rising edges only, never levels.
// - speed is thirty centimetre spacing divided by measured interval.
// - speeds below one thousand m/s show tenths of m/s.
// - speeds from one thousand to fifteen hundred show whole m/s.
// - clock period resolves the top speed within one m/s.
// - after a measurement wait two seconds before re-arming.
// - sixty seconds after a result, show four dashes.
// - speed is shown as decimal digits on seven segments.
// - no stop within 330 ms: show dashes and re-arm.
// - interval faster than fifteen hundred m/s shows four zeros.
module projectile_speed_timer
  import speed_timer_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF,
  parameter int unsigned HOLDOFF_CYCLES = HOLDOFF_CYCLES_DEF,
  parameter int unsigned IDLE_CYCLES    = IDLE_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  // gate trigger lines
  input  wire logic                  gateFirst,
  input  wire logic                  gateSecond,
  // display, digit 0 in the low byte, bit 7 of each byte the point
  output logic [8*DIGITS-1:0]        segments,
  // status
  output logic                       armed
);

  localparam int unsigned CNT_W  = $clog2(TIMEOUT_CYCLES + 1);
  localparam int unsigned HOLD_W = $clog2(HOLDOFF_CYCLES + 1);
  localparam int unsigned IDLE_W = $clog2(IDLE_CYCLES + 1);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // the 1000 m/s interval must fit below the timeout
  generate
    if (TIMEOUT_CYCLES <= WHOLE_MAX_CYCLES || HOLDOFF_CYCLES < 2 ||
        IDLE_CYCLES < 2 || CNT_W > DEND_W) begin : g_bad
      $error("projectile_speed_timer: unsupported cycle counts");
    end
  endgenerate

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic firstPrev_reg;
  logic secondPrev_reg;
  logic riseFirst;
  logic riseSecond;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      firstPrev_reg  <= 1'b0;
      secondPrev_reg <= 1'b0;
    end else begin
      firstPrev_reg  <= gateFirst;
      secondPrev_reg <= gateSecond;
    end
  end

  assign riseFirst  = gateFirst & ~firstPrev_reg;
  assign riseSecond = gateSecond & ~secondPrev_reg;

  // ----------------------------------------------------------------
  // measurement sequence
  // ----------------------------------------------------------------
  state_t           state_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] interval;
  logic [HOLD_W-1:0] holdCnt_reg;
  logic             wholeMode_reg;
  logic             divStart_reg;
  logic             bcdStart_reg;
  logic             zeroEvt_reg;
  logic             timeoutEvt_reg;
  logic             divDone;
  logic             bcdDone;
  logic [DEND_W-1:0] quotient;
  logic [4*DIGITS-1:0] bcdDigits;
  logic             stopNow;
  logic             timeoutNow;
  logic             holdDone;

  // the edge seen one cycle after the start edge is one cycle long
  assign interval   = count_reg + CNT_W'(1);
  assign stopNow    = (state_reg == ST_MEASURE) && riseSecond;
  // a stop edge in the last cycle still counts as a measurement
  assign timeoutNow = (state_reg == ST_MEASURE) && !riseSecond &&
                      (count_reg == CNT_W'(TIMEOUT_CYCLES - 1));
  assign holdDone   = (holdCnt_reg == HOLD_W'(HOLDOFF_CYCLES - 1));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg      <= ST_ARMED;
      count_reg      <= '0;
      wholeMode_reg  <= 1'b0;
      divStart_reg   <= 1'b0;
      bcdStart_reg   <= 1'b0;
      zeroEvt_reg    <= 1'b0;
      timeoutEvt_reg <= 1'b0;
    end else begin
      divStart_reg   <= 1'b0;
      bcdStart_reg   <= 1'b0;
      zeroEvt_reg    <= 1'b0;
      timeoutEvt_reg <= 1'b0;
      unique case (state_reg)
        ST_ARMED: begin
          // a second-gate edge here has nothing to stop
          if (riseFirst) begin
            state_reg <= ST_MEASURE;
            count_reg <= '0;
          end
        end
        ST_MEASURE: begin
          count_reg <= count_reg + CNT_W'(1);
          if (stopNow) begin
            if (interval < CNT_W'(MIN_CYCLES)) begin
              zeroEvt_reg <= 1'b1;
              state_reg   <= ST_HOLD;
            end else begin
              wholeMode_reg <= (interval <= CNT_W'(WHOLE_MAX_CYCLES));
              divStart_reg  <= 1'b1;
              state_reg     <= ST_DIVIDE;
            end
          end else if (timeoutNow) begin
            timeoutEvt_reg <= 1'b1;
            state_reg      <= ST_ARMED;
          end
        end
        ST_DIVIDE: begin
          if (divDone) begin
            bcdStart_reg <= 1'b1;
            state_reg    <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (bcdDone) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (holdDone) begin
            state_reg <= ST_ARMED;
          end
        end
      endcase
    end
  end

  // first-gate edges during the hold-off fall through unseen
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt_reg <= '0;
    end else if (state_reg == ST_HOLD) begin
      holdCnt_reg <= holdCnt_reg + HOLD_W'(1);
    end else begin
      holdCnt_reg <= '0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      armed <= 1'b1;
    end else begin
      armed <= (state_reg == ST_ARMED && !riseFirst) ||
               (state_reg == ST_HOLD && holdDone) || timeoutNow;
    end
  end

  // ----------------------------------------------------------------
  // speed arithmetic
  // ----------------------------------------------------------------
  // 50 ns ticks give 1500.4 m/s for one tick short at the top speed,
  // so truncating division stays inside one metre per second
  speed_divider #(
    .DEND_WIDTH (DEND_W),
    .DSOR_WIDTH (CNT_W)
  ) u_divider (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .start    (divStart_reg),
    .dividend (wholeMode_reg ? DEND_W'(SPEED_WHOLE_NUM)
                             : DEND_W'(SPEED_TENTH_NUM)),
    // the count has stepped to the interval itself once stop is taken
    .divisor  (count_reg),
    .done     (divDone),
    .quotient (quotient)
  );

  bin_to_bcd #(
    .BIN_WIDTH  (QUO_W),
    .NUM_DIGITS (DIGITS)
  ) u_bcd (
    .mclk   (mclk),
    .arst_n (arst_n),
    .start  (bcdStart_reg),
    .bin    (quotient[QUO_W-1:0]),
    .done   (bcdDone),
    .bcd    (bcdDigits)
  );

  // ----------------------------------------------------------------
  // display mode and idle blanking
  // ----------------------------------------------------------------
  dispMode_t         dispMode_reg;
  logic              fine_reg;
  logic [IDLE_W-1:0] idleCnt_reg;
  logic              idleDone;
  // digits are latched so a conversion under way never reaches the pins
  logic [4*DIGITS-1:0] shown_reg;

  assign idleDone = (idleCnt_reg == IDLE_W'(IDLE_CYCLES - 1));

  // a fresh result restarts the idle count even in its last cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idleCnt_reg <= '0;
    end else if (bcdDone || zeroEvt_reg || dispMode_reg == DM_DASH) begin
      idleCnt_reg <= '0;
    end else begin
      idleCnt_reg <= idleCnt_reg + IDLE_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dispMode_reg <= DM_DASH;
      fine_reg     <= 1'b0;
      shown_reg    <= '0;
    end else if (bcdDone) begin
      dispMode_reg <= DM_VALUE;
      shown_reg    <= bcdDigits;
      fine_reg     <= !wholeMode_reg;
    end else if (zeroEvt_reg) begin
      dispMode_reg <= DM_ZERO;
    end else if (timeoutEvt_reg) begin
      dispMode_reg <= DM_DASH;
    end else if (idleDone) begin
      dispMode_reg <= DM_DASH;
    end
  end

  // ----------------------------------------------------------------
  // segment drivers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DIGITS; i++) begin : g_digit
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        segments[8*i+:8] <= {1'b0, SEG_DASH};
      end else begin
        unique case (dispMode_reg)
          DM_DASH:  segments[8*i+:8] <= {1'b0, SEG_DASH};
          DM_ZERO:  segments[8*i+:8] <= {1'b0, SEG_ZERO};
          DM_VALUE: segments[8*i+:8] <=
            {fine_reg && (i == FINE_DP_DIGIT), seg_of(shown_reg[4*i+:4])};
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_start_on_rise: assert property (
    state_reg == ST_ARMED && riseFirst |=>
      state_reg == ST_MEASURE && count_reg == '0)
    else $error("first gate edge did not start the count");

  chk_stop_on_rise: assert property (
    stopNow |=> state_reg inside {ST_DIVIDE, ST_HOLD})
    else $error("second gate edge did not stop the count");

  chk_level_no_stop: assert property (
    state_reg == ST_MEASURE && gateSecond && secondPrev_reg &&
      !timeoutNow |=> state_reg == ST_MEASURE)
    else $error("steady second gate level ended the measurement");

  chk_divide_bound: assert property (
    $rose(state_reg == ST_DIVIDE) |-> ##[26:28] state_reg == ST_CONVERT)
    else $error("division took the wrong number of cycles");

  chk_fine_point: assert property (
    dispMode_reg == DM_VALUE && fine_reg |=> segments[15])
    else $error("tenths result lacks its decimal point");

  chk_whole_point: assert property (
    dispMode_reg == DM_VALUE && !fine_reg |=> !segments[15])
    else $error("whole result shows a decimal point");

  chk_holdoff_len: assert property (
    $past(state_reg) == ST_HOLD && state_reg == ST_ARMED |->
      $past(holdCnt_reg) == HOLD_W'(HOLDOFF_CYCLES - 1))
    else $error("hold-off ended at the wrong count");

  chk_idle_blank: assert property (
    dispMode_reg != DM_DASH && idleDone && !bcdDone && !zeroEvt_reg
      |=> dispMode_reg == DM_DASH ##1 segments[6:0] == SEG_DASH)
    else $error("idle timeout did not blank the display");

  chk_timeout_dash: assert property (
    timeoutNow |=> state_reg == ST_ARMED ##1 dispMode_reg == DM_DASH)
    else $error("timeout did not show dashes and re-arm");

  chk_short_zero: assert property (
    stopNow && interval < CNT_W'(MIN_CYCLES) |=>
      state_reg == ST_HOLD ##1 dispMode_reg == DM_ZERO
      ##1 segments[6:0] == SEG_ZERO)
    else $error("too short interval did not show zeros");

  chk_first_ignored: assert property (
    state_reg != ST_ARMED && riseFirst && !timeoutNow &&
      !(state_reg == ST_HOLD && holdDone) |=>
      !(state_reg == ST_MEASURE && count_reg == '0))
    else $error("first gate edge restarted a busy measurement");

  cov_value_shown: cover property ($rose(dispMode_reg == DM_VALUE));
  cov_zero_shown:  cover property (zeroEvt_reg);
  cov_timeout:     cover property (timeoutEvt_reg);
  cov_idle_blank:  cover property (idleDone && dispMode_reg != DM_DASH);

endmodule // projectile_speed_timer

// *** shared/speed_timer_pkg.sv ***
package speed_timer_pkg;

  // ----------------------------------------------------------------
  // clock and geometry
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned GATE_SPACING_CM = 30;

  // speed in m/s equals this numerator over the interval in cycles
  localparam longint unsigned SPEED_WHOLE_NUM =
    longint'(GATE_SPACING_CM) * CLK_HZ / 100;
  localparam longint unsigned SPEED_TENTH_NUM = SPEED_WHOLE_NUM * 10;

  // ----------------------------------------------------------------
  // speed range limits
  // ----------------------------------------------------------------
  localparam int unsigned SPEED_FINE_MAX_MPS = 1000;
  localparam int unsigned SPEED_TOP_MPS      = 1500;
  // intervals at or below this show whole metres per second
  localparam int unsigned WHOLE_MAX_CYCLES =
    32'(SPEED_WHOLE_NUM / SPEED_FINE_MAX_MPS);
  // intervals below this are faster than the top speed
  localparam int unsigned MIN_CYCLES =
    32'(SPEED_WHOLE_NUM / SPEED_TOP_MPS);

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned TIMEOUT_MS = 330;
  localparam int unsigned HOLDOFF_MS = 2000;
  localparam int unsigned IDLE_S     = 60;
  localparam int unsigned TIMEOUT_CYCLES_DEF = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLDOFF_CYCLES_DEF = HOLDOFF_MS * (CLK_HZ / 1000);
  localparam int unsigned IDLE_CYCLES_DEF    = IDLE_S * CLK_HZ;

  // ----------------------------------------------------------------
  // arithmetic and display layout
  // ----------------------------------------------------------------
  localparam int unsigned DIGITS        = 4;
  localparam int unsigned QUO_W         = 14;
  localparam int unsigned DEND_W        = 26;
  localparam int unsigned DP_BIT        = 7;
  localparam int unsigned FINE_DP_DIGIT = 1;
  localparam logic [6:0]  SEG_DASH      = 7'h40;
  localparam logic [6:0]  SEG_ZERO      = 7'h3F;

  typedef enum logic [2:0] {
    ST_ARMED, ST_MEASURE, ST_DIVIDE, ST_CONVERT, ST_HOLD
  } state_t;

  typedef enum logic [1:0] {DM_DASH, DM_ZERO, DM_VALUE} dispMode_t;

  // common cathode, bit 0 = segment a
  function automatic logic [6:0] seg_of(input logic [3:0] d);
    logic [6:0] s;
    s = SEG_DASH;
    unique case (d)
      4'h0: s = 7'h3F;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5B;
      4'h3: s = 7'h4F;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6D;
      4'h6: s = 7'h7D;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7F;
      4'h9: s = 7'h6F;
      default: s = SEG_DASH;
    endcase
    return s;
  endfunction

endpackage

// *** logic/speed_divider.sv ***
`timescale 1ns/1ns
module speed_divider
  import speed_timer_pkg::*;
#(
  parameter int unsigned DEND_WIDTH = 26,
  parameter int unsigned DSOR_WIDTH = 23
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  // request
  input  wire logic                  start,
  input  wire logic [DEND_WIDTH-1:0] dividend,
  input  wire logic [DSOR_WIDTH-1:0] divisor,
  // answer
  output logic                       done,
  output logic [DEND_WIDTH-1:0]      quotient
);

  localparam int unsigned CW = $clog2(DEND_WIDTH + 1);

  generate
    if (DSOR_WIDTH > DEND_WIDTH || DEND_WIDTH < 2) begin : g_bad
      $error("speed_divider: unsupported widths");
    end
  endgenerate

  logic [DSOR_WIDTH:0] rem_reg;
  logic [CW-1:0]       cnt_reg;
  logic                busy_reg;
  logic [DSOR_WIDTH:0] trial;

  assign trial = {rem_reg[DSOR_WIDTH-1:0], quotient[DEND_WIDTH-1]};

  // restoring division, one quotient bit per cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rem_reg  <= '0;
      quotient <= '0;
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem_reg  <= '0;
        quotient <= dividend;
        cnt_reg  <= CW'(DEND_WIDTH);
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (trial >= {1'b0, divisor}) begin
          rem_reg  <= trial - {1'b0, divisor};
          quotient <= {quotient[DEND_WIDTH-2:0], 1'b1};
        end else begin
          rem_reg  <= trial;
          quotient <= {quotient[DEND_WIDTH-2:0], 1'b0};
        end
        cnt_reg <= cnt_reg - CW'(1);
        if (cnt_reg == CW'(1)) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
        end
      end
    end
  end

endmodule // speed_divider

// *** logic/bin_to_bcd.sv ***
`timescale 1ns/1ns
module bin_to_bcd
  import speed_timer_pkg::*;
#(
  parameter int unsigned BIN_WIDTH  = 14,
  parameter int unsigned NUM_DIGITS = 4
) (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    arst_n,
  // request
  input  wire logic                    start,
  input  wire logic [BIN_WIDTH-1:0]    bin,
  // answer
  output logic                         done,
  output logic [4*NUM_DIGITS-1:0]      bcd
);

  localparam int unsigned CW = $clog2(BIN_WIDTH + 1);

  generate
    if (NUM_DIGITS < 1 || BIN_WIDTH < 2) begin : g_bad
      $error("bin_to_bcd: unsupported widths");
    end
  endgenerate

  logic [BIN_WIDTH-1:0]    bin_reg;
  logic [CW-1:0]           cnt_reg;
  logic                    busy_reg;
  logic [4*NUM_DIGITS-1:0] adj;

  // add three to every nibble above four before each shift
  for (genvar i = 0; i < NUM_DIGITS; i++) begin : g_adj
    assign adj[4*i+:4] = (bcd[4*i+:4] > 4'h4) ? bcd[4*i+:4] + 4'h3
                                               : bcd[4*i+:4];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bin_reg  <= '0;
      bcd      <= '0;
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        bin_reg  <= bin;
        bcd      <= '0;
        cnt_reg  <= CW'(BIN_WIDTH);
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        bcd     <= {adj[4*NUM_DIGITS-2:0], bin_reg[BIN_WIDTH-1]};
        bin_reg <= {bin_reg[BIN_WIDTH-2:0], 1'b0};
        cnt_reg <= cnt_reg - CW'(1);
        if (cnt_reg == CW'(1)) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
        end
      end
    end
  end

endmodule // bin_to_bcd

// *** testbench/gate_board.sv ***
`timescale 1ns/1ns
module gate_board (
  // light comparator outputs, high while a beam is blocked
  input  wire logic [5:0] lightComparator,
  // trigger line to the main board
  output logic            trigger
);
  // any one blocked beam raises the line; with no beam blocked the OR leaves it low
  assign trigger = |lightComparator;
endmodule // gate_board

// *** testbench/projectile_speed_timer_bench.sv ***
`timescale 1ns/1ns
module projectile_speed_timer_bench;
  import speed_timer_pkg::*;

  // ----------------------------------------------------------------
  // setup
  // ----------------------------------------------------------------
  // shortened counts so the run stays short
  localparam int unsigned TO_CYC = 8000;
  localparam int unsigned HO_CYC = 50;
  // idle span outlasts a timeout so a standing result meets the timeout
  localparam int unsigned ID_CYC = 10000;
  localparam logic [31:0] DASHES = {4{8'h40}};
  localparam logic [31:0] ZEROS  = {4{8'h3F}};

  typedef struct {
    int          n;
    logic [15:0] bcd;
    logic        pt;
  } row_t;

  logic                mclk;
  logic                arst_n;
  logic [5:0]          beamA;
  logic [5:0]          beamB;
  logic                gateFirst;
  logic                gateSecond;
  logic [8*DIGITS-1:0] segments;
  logic                armed;
  int                  n_fail;
  int                  checks;
  int                  i;
  row_t                rows [8];

  gate_board firstBoard (.lightComparator(beamA), .trigger(gateFirst));
  gate_board secondBoard (.lightComparator(beamB), .trigger(gateSecond));

  projectile_speed_timer #(
    .TIMEOUT_CYCLES (TO_CYC),
    .HOLDOFF_CYCLES (HO_CYC),
    .IDLE_CYCLES    (ID_CYC)
  ) DUT (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .gateFirst  (gateFirst),
    .gateSecond (gateSecond),
    .segments   (segments),
    .armed      (armed)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] expect_seg(input logic [15:0] bcd,
                                             input logic        pt);
    logic [6:0]  tbl [10];
    logic [31:0] r;
    tbl = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
            7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
    for (int d = 0; d < 4; d++)
      r[8*d +: 8] = {pt && d == 1, tbl[bcd[4*d +: 4]]};
    return r;
  endfunction

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge mclk);
  endtask

  // the result latency is not fixed, so poll under a bound
  task automatic wait_seg(input logic [31:0] exp, input int lim);
    int k;
    for (k = 0; k < lim && segments !== exp; k++)
      @(negedge mclk);
    cmp32(segments, exp);
  endtask

  task automatic wait_armed(input int lim);
    int k;
    for (k = 0; k < lim && armed !== 1'b1; k++)
      @(negedge mclk);
    cmp1(armed, 1'b1);
  endtask

  // second beam is cut n cycles after the first, via comparator c
  task automatic shot(input int n, input int c);
    beamA[c] = 1'b1;
    cycles(n);
    beamB[c] = 1'b1;
    cycles(3);
    beamA = '0;
    beamB = '0;
  endtask

  task automatic summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    beamA  = '0;
    beamB  = '0;
    n_fail = 0;
    checks = 0;
    rows = '{'{3999, 16'h0000, 1'b0}, '{4000, 16'h1500, 1'b0},
             '{4001, 16'h1499, 1'b0}, '{5000, 16'h1200, 1'b0},
             '{6000, 16'h1000, 1'b0}, '{6001, 16'h9998, 1'b1},
             '{7999, 16'h7500, 1'b1}, '{1, 16'h0000, 1'b0}};
    cycles(12);
    cmp32(segments, DASHES);
    cmp1(armed, 1'b1);
    arst_n = 1'b1;

    for (i = 0; i < 8; i++) begin
      wait_armed(HO_CYC + 100);
      shot(rows[i].n, i % 6);
      wait_seg(expect_seg(rows[i].bcd, rows[i].pt), 80);
      cmp1(armed, 1'b0);
    end

    // zeros stand until the idle count runs out, then dashes
    cycles(ID_CYC - 20);
    cmp32(segments, ZEROS);
    wait_seg(DASHES, 40);

    // a stray second edge while armed starts nothing
    beamB[4] = 1'b1;
    cycles(5);
    cmp1(armed, 1'b1);
    cmp32(segments, DASHES);
    beamB = '0;
    cycles(2);

    // first gate re-rises mid measurement; count keeps its start
    beamA[2] = 1'b1;
    cycles(2000);
    beamA = '0;
    cycles(10);
    beamA[3] = 1'b1;
    cycles(3990);
    beamB[0] = 1'b1;
    wait_seg(expect_seg(16'h1000, 1'b0), 80);
    cycles(HO_CYC - 5);
    cmp1(armed, 1'b0);
    wait_armed(20);
    // first line still high: a level must not start a measurement
    cycles(10);
    cmp1(armed, 1'b1);
    beamA = '0;
    cycles(2);

    // second line held high, never rising: timeout re-arms, no hold-off
    beamA[5] = 1'b1;
    cycles(5);
    cmp1(armed, 1'b0);
    cycles(TO_CYC - 20);
    cmp1(armed, 1'b0);
    wait_armed(30);
    wait_seg(DASHES, 5);
    beamA = '0;
    beamB = '0;
    cycles(2);

    // reset in mid-run clears a standing result
    shot(5000, 1);
    wait_seg(expect_seg(16'h1200, 1'b0), 80);
    arst_n = 1'b0;
    cycles(2);
    cmp32(segments, DASHES);
    cmp1(armed, 1'b1);
    arst_n = 1'b1;
    cycles(2);
    cmp32(segments, DASHES);
    summarize();
  end
endmodule // projectile_speed_timer_bench
